// File: verilog/xmpc_pkg.sv
package xmpc_pkg;

    // =====================================================================
    // Register map in external data space.
    // =====================================================================
    localparam logic [15:0] XMPC_ADDR_CONFIG = 16'h0200;
    localparam logic [15:0] XMPC_ADDR_LOW    = 16'h0201;
    localparam logic [15:0] XMPC_ADDR_HIGH   = 16'h0202;
    localparam logic [15:0] XMPC_AUX_TOP     = 16'h0200;

    // =====================================================================
    // Field positions and reset values.
    // =====================================================================
    localparam int          XMPC_LOW_SEL_BIT  = 3;
    localparam int          XMPC_HIGH_SEL_BIT = 4;
    localparam logic [7:0]  XMPC_CFG_MASK     = 8'h18;
    localparam logic [7:0]  XMPC_RST_BYTE     = 8'h00;
    localparam logic [7:0]  XMPC_ZERO_BYTE    = 8'h00;

    // =====================================================================
    // Carriers.
    // =====================================================================
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } xmpc_xreq_t;

    typedef struct packed {
        logic        aux_ram_disable;
        logic        extended_addressing_mode;
        logic        port4_bit3_latch;
    } xmpc_gate_t;

    typedef enum logic [1:0] {
        XMPC_REG_CONFIG = 2'b00,
        XMPC_REG_LOW    = 2'b01,
        XMPC_REG_HIGH   = 2'b10,
        XMPC_REG_NONE   = 2'b11
    } xmpc_reg_sel_t;

endpackage

// File: verilog/xmpc_pin_sync.sv
`timescale 1ns/1ns
module xmpc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             core_clk,   // Core clock.
    input  wire logic             rst_b,      // Async reset, active low.
    input  wire logic [WIDTH-1:0] async_in,   // Pin level.
    output logic      [WIDTH-1:0] sync_out    // Synchronised level.
);
    import xmpc_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // =====================================================================
    // Two-stage synchroniser; only the second stage is read outside.
    // =====================================================================
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

// File: verilog/xmpc_ext_mem_port.sv
`timescale 1ns/1ns
module xmpc_ext_mem_port (
    input  wire logic               core_clk,                  // 250 MHz core clock.
    input  wire logic               rst_b,                     // Async reset, active low.
    input  wire logic               external_access_input_b,   // Pin, low selects external code.
    input  wire xmpc_pkg::xmpc_xreq_t xreq,                    // External data move request.
    input  wire xmpc_pkg::xmpc_gate_t gate,                    // Access gating controls.
    input  wire logic               addr_latch_en,             // Address latch enable strobe.
    input  wire logic [7:0]         internal_low_address,      // Internal low address byte.
    input  wire logic [7:0]         internal_high_address_bus, // Internal high address bus.
    output logic      [7:0]         xrdata,                    // Register read data.
    output logic                    xrdata_valid,              // Register read answered.
    output logic                    ext_wr_strobe,             // External write strobe enable.
    output logic                    ext_rd_strobe,             // External read strobe enable.
    output logic                    internal_rom_enable,       // Internal program ROM enable.
    output logic                    data_only_mux_port,        // Multiplexed port carries data only.
    output logic      [7:0]         low_address_port,          // Low-address port pins.
    output logic      [7:0]         high_address_port          // High-address port pins.
);
    import xmpc_pkg::*;

    logic          ext_access_sync;
    logic [7:0]    cfg_q;
    logic [7:0]    cfg_d;
    logic [7:0]    low_val_q;
    logic [7:0]    low_val_d;
    logic [7:0]    high_val_q;
    logic [7:0]    high_val_d;
    logic [7:0]    low_addr_q;
    logic [7:0]    low_addr_d;
    logic [7:0]    rdata_q;
    logic [7:0]    rdata_d;
    logic          rvalid_q;
    logic          rvalid_d;
    logic          access_ok;
    logic          hit;
    logic          below_aux;
    xmpc_reg_sel_t sel;
    logic          low_is_addr;
    logic          high_is_addr;

    // =====================================================================
    // External access pin synchroniser.
    // =====================================================================
    xmpc_pin_sync #(
        .WIDTH (1)
    ) u_ea_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .async_in (external_access_input_b),
        .sync_out (ext_access_sync)
    );

    // =====================================================================
    // Address decode and access gating.
    // =====================================================================
    always_comb begin
        case (xreq.addr)
            XMPC_ADDR_CONFIG: sel = XMPC_REG_CONFIG;
            XMPC_ADDR_LOW:    sel = XMPC_REG_LOW;
            XMPC_ADDR_HIGH:   sel = XMPC_REG_HIGH;
            default:          sel = XMPC_REG_NONE;
        endcase
        if (gate.extended_addressing_mode) begin
            access_ok = !gate.aux_ram_disable;
        end else begin
            access_ok = gate.port4_bit3_latch;
        end
        hit       = (sel != XMPC_REG_NONE) && access_ok;
        below_aux = xreq.addr < XMPC_AUX_TOP;
    end

    // External strobes are withheld for register hits and for suppressed aux RAM.
    always_comb begin
        ext_wr_strobe = xreq.wr && !hit;
        ext_rd_strobe = xreq.rd && !hit;
        if (gate.extended_addressing_mode && gate.aux_ram_disable && below_aux) begin
            ext_wr_strobe = 1'b0;
            ext_rd_strobe = 1'b0;
        end
    end

    // =====================================================================
    // Register file.
    // =====================================================================
    always_comb begin
        cfg_d      = cfg_q;
        low_val_d  = low_val_q;
        high_val_d = high_val_q;
        rdata_d    = rdata_q;
        rvalid_d   = 1'b0;
        if (xreq.wr && hit) begin
            case (sel)
                XMPC_REG_CONFIG: cfg_d      = xreq.wdata & XMPC_CFG_MASK;
                XMPC_REG_LOW:    low_val_d  = xreq.wdata;
                XMPC_REG_HIGH:   high_val_d = xreq.wdata;
                default:         cfg_d      = cfg_q;
            endcase
        end
        if (xreq.rd && hit) begin
            rvalid_d = 1'b1;
            case (sel)
                XMPC_REG_CONFIG: rdata_d = cfg_q;
                XMPC_REG_LOW:    rdata_d = low_val_q;
                XMPC_REG_HIGH:   rdata_d = high_val_q;
                default:         rdata_d = XMPC_ZERO_BYTE;
            endcase
        end
    end

    // =====================================================================
    // Port role selection.
    // =====================================================================
    always_comb begin
        internal_rom_enable = ext_access_sync;
        data_only_mux_port  = ext_access_sync;
        if (!ext_access_sync) begin
            low_is_addr  = 1'b1;
            high_is_addr = 1'b1;
        end else begin
            low_is_addr  = cfg_q[XMPC_LOW_SEL_BIT];
            high_is_addr = cfg_q[XMPC_HIGH_SEL_BIT];
        end
        low_addr_d = low_addr_q;
        if (addr_latch_en) begin
            low_addr_d = internal_low_address;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q      <= XMPC_RST_BYTE;
            low_val_q  <= XMPC_RST_BYTE;
            high_val_q <= XMPC_RST_BYTE;
            low_addr_q <= XMPC_RST_BYTE;
            rdata_q    <= XMPC_RST_BYTE;
            rvalid_q   <= 1'b0;
        end else begin
            cfg_q      <= cfg_d;
            low_val_q  <= low_val_d;
            high_val_q <= high_val_d;
            low_addr_q <= low_addr_d;
            rdata_q    <= rdata_d;
            rvalid_q   <= rvalid_d;
        end
    end

    // Low port: latched address or general-purpose value.
    assign low_address_port = low_is_addr ? low_addr_q : low_val_q;
    // High port: unlatched internal address bus or the software latch.
    assign high_address_port = high_is_addr ? internal_high_address_bus
                                            : high_val_q;
    assign xrdata       = rdata_q;
    assign xrdata_valid = rvalid_q;

    // =====================================================================
    // Checks.
    // =====================================================================
    chk_low_gp_value: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ext_access_sync && !cfg_q[XMPC_LOW_SEL_BIT]) |-> low_address_port == low_val_q)
        else $error("Low port not showing its register.");

    chk_low_addr_latch: assert property (@(posedge core_clk) disable iff (!rst_b)
        (addr_latch_en ##1 (low_is_addr && !addr_latch_en))
            |-> low_address_port == $past(internal_low_address))
        else $error("Low address not latched on strobe.");

    chk_high_passthru: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ext_access_sync || cfg_q[XMPC_HIGH_SEL_BIT])
            |-> high_address_port == internal_high_address_bus)
        else $error("High address not passed through.");

    chk_ext_forces_addr: assert property (@(posedge core_clk) disable iff (!rst_b)
        !ext_access_sync |-> (low_address_port == low_addr_q) && !internal_rom_enable)
        else $error("External access did not force address role.");

    chk_low_reg_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && access_ok && xreq.addr == XMPC_ADDR_LOW)
            |=> low_val_q == $past(xreq.wdata))
        else $error("Low register write lost.");

    chk_gate_mode0: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && !gate.extended_addressing_mode && !gate.port4_bit3_latch)
            |=> $stable(cfg_q) && $stable(high_val_q) && $stable(low_val_q))
        else $error("Register write passed while gated off.");

    chk_strobe_suppress: assert property (@(posedge core_clk) disable iff (!rst_b)
        (gate.extended_addressing_mode && gate.aux_ram_disable && below_aux)
            |-> !ext_wr_strobe && !ext_rd_strobe)
        else $error("Strobe not suppressed below aux top.");

    chk_read_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.rd && hit && xreq.addr == XMPC_ADDR_HIGH)
            |-> !ext_rd_strobe ##1 (xrdata_valid && xrdata == $past(high_val_q)))
        else $error("Register read answer wrong.");

    // =====================================================================
    // Port roles.
    // =====================================================================
    // Roles are judged from the pin and the select bits, not from the mux selects.
    chk_low_addr_role: assert property (@(posedge core_clk) disable iff (!rst_b)
        (!ext_access_sync || cfg_q[XMPC_LOW_SEL_BIT])
            |-> low_address_port == low_addr_q)
        else $error("Low port not showing latched address.");

    chk_low_addr_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        !addr_latch_en |=> $stable(low_addr_q))
        else $error("Low address latch moved without strobe.");

    chk_high_gp_value: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ext_access_sync && !cfg_q[XMPC_HIGH_SEL_BIT])
            |-> high_address_port == high_val_q)
        else $error("High port not showing its register.");

    chk_high_addr_role: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ext_access_sync && !cfg_q[XMPC_LOW_SEL_BIT] && cfg_q[XMPC_HIGH_SEL_BIT])
            |-> (high_address_port == internal_high_address_bus)
                && (low_address_port == low_val_q))
        else $error("High address role not independent.");

    chk_split_roles: assert property (@(posedge core_clk) disable iff (!rst_b)
        (ext_access_sync && cfg_q[XMPC_LOW_SEL_BIT] && !cfg_q[XMPC_HIGH_SEL_BIT])
            |-> (low_address_port == low_addr_q) && (high_address_port == high_val_q))
        else $error("Low address role not independent.");

    chk_rom_follows_pin: assert property (@(posedge core_clk) disable iff (!rst_b)
        $changed(internal_rom_enable)
            |-> internal_rom_enable == $past(external_access_input_b, 2))
        else $error("ROM enable does not follow the pin.");

    // =====================================================================
    // Register contents and gating.
    // =====================================================================
    chk_cfg_write_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && access_ok && xreq.addr == XMPC_ADDR_CONFIG)
            |=> cfg_q == ($past(xreq.wdata) & XMPC_CFG_MASK))
        else $error("Config write not masked to select bits.");

    chk_cfg_spare_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
        (cfg_q & ~XMPC_CFG_MASK) == XMPC_ZERO_BYTE)
        else $error("Config spare bits not zero.");

    chk_high_reg_write: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && access_ok && xreq.addr == XMPC_ADDR_HIGH)
            |=> high_val_q == $past(xreq.wdata))
        else $error("High register write lost.");

    chk_gate_mode1: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && gate.extended_addressing_mode && gate.aux_ram_disable)
            |=> $stable(cfg_q) && $stable(high_val_q) && $stable(low_val_q))
        else $error("Register write passed with aux RAM disabled.");

    chk_mode1_latch_free: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.wr && gate.extended_addressing_mode && !gate.aux_ram_disable
            && !gate.port4_bit3_latch && xreq.addr == XMPC_ADDR_LOW)
            |=> low_val_q == $past(xreq.wdata))
        else $error("Extended mode write wrongly needed latch.");

    chk_ext_rd_passes: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.rd && !hit && !below_aux)
            |-> ext_rd_strobe)
        else $error("External read strobe wrongly withheld.");

    // =====================================================================
    // Reads.
    // =====================================================================
    chk_unmapped_no_valid: assert property (@(posedge core_clk) disable iff (!rst_b)
        (xreq.rd && (xreq.addr < XMPC_ADDR_CONFIG || xreq.addr > XMPC_ADDR_HIGH))
            |=> !xrdata_valid)
        else $error("Unmapped read answered as register.");

    chk_hit_no_strobe: assert property (@(posedge core_clk) disable iff (!rst_b)
        hit |-> !ext_wr_strobe && !ext_rd_strobe)
        else $error("Register hit reached the external bus.");

    chk_valid_needs_read: assert property (@(posedge core_clk) disable iff (!rst_b)
        xrdata_valid
            |-> $past(xreq.rd) && $past(hit))
        else $error("Read valid without register read.");

    chk_rdata_holds: assert property (@(posedge core_clk) disable iff (!rst_b)
        !(xreq.rd && hit)
            |=> $stable(xrdata))
        else $error("Read data changed without register read.");

endmodule

// File: verification/xmpc_ext_mem_model.sv
`timescale 1ns/1ns
module xmpc_ext_mem_model (
    input  wire logic       core_clk,      // Core clock.
    input  wire logic       rst_b,         // Async reset, active low.
    input  wire logic       ext_wr_strobe, // External write strobe enable.
    input  wire logic       ext_rd_strobe, // External read strobe enable.
    output logic      [7:0] ext_cycles     // External bus cycles seen.
);
    // =====================================================================
    // External memory side: counts every cycle that reaches the pins.
    // =====================================================================
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ext_cycles <= 8'h00;
        end else if (ext_wr_strobe || ext_rd_strobe) begin
            ext_cycles <= ext_cycles + 8'h01;
        end
    end
endmodule

// File: verification/test_xmpc_ext_mem_port.sv
`timescale 1ns/1ns
module test_xmpc_ext_mem_port;
    import xmpc_pkg::*;
    logic       core_clk = 1'b0;
    logic       rst_b    = 1'b0;
    logic       ext_access_b = 1'b1;
    xmpc_xreq_t xreq     = '0;
    xmpc_gate_t gate     = 3'b001;
    logic       ale      = 1'b0;
    logic [7:0] ilow     = 8'h00;
    logic [7:0] ihigh    = 8'h00;
    logic [7:0] xrdata, lo_p, hi_p, ext_cycles;
    logic       xrdata_valid, wr_s, rd_s, rom_en, data_only;
    int         fail_count = 0;
    int         num_checks = 0;

    always #2 core_clk = ~core_clk;

    xmpc_ext_mem_port dut_u (.core_clk(core_clk), .rst_b(rst_b),
        .external_access_input_b(ext_access_b), .xreq(xreq), .gate(gate), .addr_latch_en(ale),
        .internal_low_address(ilow), .internal_high_address_bus(ihigh), .xrdata(xrdata),
        .xrdata_valid(xrdata_valid), .ext_wr_strobe(wr_s), .ext_rd_strobe(rd_s),
        .internal_rom_enable(rom_en), .data_only_mux_port(data_only),
        .low_address_port(lo_p), .high_address_port(hi_p));

    xmpc_ext_mem_model mem_u (.core_clk(core_clk), .rst_b(rst_b), .ext_wr_strobe(wr_s),
        .ext_rd_strobe(rd_s), .ext_cycles(ext_cycles));

    // =====================================================================
    // Shared tasks.
    // =====================================================================
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        xreq <= '{w, r, a, d};
        @(posedge core_clk);
        xreq <= '0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, a, 8'h00);
        chk({7'h00, xrdata_valid}, 8'h01);
        chk(xrdata, exp);
    endtask

    task automatic close_out;
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // =====================================================================
    // Scenarios.
    // =====================================================================
    task automatic t_reset;
        rd(XMPC_ADDR_CONFIG, 8'h00);
        rd(XMPC_ADDR_LOW, 8'h00);
        rd(XMPC_ADDR_HIGH, 8'h00);
        chk(lo_p, 8'h00);
        chk(hi_p, 8'h00);
        chk({6'h00, rom_en, data_only}, 8'h03);
    endtask

    task automatic t_regs;
        acc(1'b1, 1'b0, XMPC_ADDR_LOW, 8'h5A);
        acc(1'b1, 1'b0, XMPC_ADDR_HIGH, 8'hA5);
        chk(lo_p, 8'h5A);
        chk(hi_p, 8'hA5);
        rd(XMPC_ADDR_LOW, 8'h5A);
        acc(1'b1, 1'b0, XMPC_ADDR_CONFIG, 8'hFF);
        rd(XMPC_ADDR_CONFIG, 8'h18);
        chk(ext_cycles, 8'h00);
        acc(1'b0, 1'b1, 16'h0203, 8'h00);
        chk({7'h00, xrdata_valid}, 8'h00);
        chk(ext_cycles, 8'h01);
    endtask

    task automatic t_addr;
        @(posedge core_clk);
        ale <= 1'b1;
        ilow <= 8'h3C;
        @(posedge core_clk);
        ale <= 1'b0;
        ilow <= 8'h00;
        ihigh <= 8'h7E;
        #1;
        chk(lo_p, 8'h3C);
        chk(hi_p, 8'h7E);
        acc(1'b1, 1'b0, XMPC_ADDR_CONFIG, 8'h08);
        chk(lo_p, 8'h3C);
        chk(hi_p, 8'hA5);
        acc(1'b1, 1'b0, XMPC_ADDR_CONFIG, 8'h10);
        chk(lo_p, 8'h5A);
        chk(hi_p, 8'h7E);
        acc(1'b1, 1'b0, XMPC_ADDR_CONFIG, 8'h00);
    endtask

    task automatic t_gate;
        @(posedge core_clk);
        gate <= 3'b000;
        acc(1'b1, 1'b0, XMPC_ADDR_LOW, 8'h11);
        chk(lo_p, 8'h5A);
        acc(1'b0, 1'b1, XMPC_ADDR_LOW, 8'h00);
        chk({7'h00, xrdata_valid}, 8'h00);
        @(posedge core_clk);
        gate <= 3'b010;
        acc(1'b1, 1'b0, XMPC_ADDR_LOW, 8'h22);
        chk(lo_p, 8'h22);
        @(posedge core_clk);
        gate <= 3'b110;
        acc(1'b1, 1'b0, XMPC_ADDR_LOW, 8'h33);
        chk(lo_p, 8'h22);
        @(posedge core_clk);
        xreq <= '{1'b1, 1'b0, 16'h01FF, 8'h00};
        #1;
        chk({6'h00, wr_s, rd_s}, 8'h00);
        @(posedge core_clk);
        xreq <= '{1'b0, 1'b1, 16'h0300, 8'h00};
        #1;
        chk({6'h00, wr_s, rd_s}, 8'h01);
        @(posedge core_clk);
        xreq <= '0;
        gate <= 3'b001;
    endtask

    task automatic t_ext_access;
        @(posedge core_clk);
        ext_access_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        chk({6'h00, rom_en, data_only}, 8'h00);
        chk(hi_p, 8'h7E);
        chk(lo_p, 8'h3C);
    endtask

    initial begin
        #20000;
        fail_count++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_regs();
        t_addr();
        t_gate();
        t_ext_access();
        close_out();
    end
endmodule
